// ### logic/cce_exec.sv
// Call and clear instruction executor with Avalon-MM register slave
`timescale 1ns/1ps

module cce_exec (
    input  wire logic        CORE_CLK,
    input  wire logic        RSTN,
    input  wire logic [11:0] INSTR_WORD,
    input  wire logic [5:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [10:0] FETCH_ADDR,
    output logic      [7:0]  STATUS_FLAGS
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0]         rst_sync_q;
    logic               rst_n;

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // Instruction cycle divider
    // ************************************************************
    logic [1:0]         div_q;
    logic [1:0]         div_d;
    logic               cyc_en;
    logic               cyc_next;

    assign cyc_en   = div_q == cce_pkg::CYC_DIV_LAST;
    assign cyc_next = div_q == cce_pkg::CYC_DIV_NEXT;

    always_comb begin
        div_d = div_q + 2'h1;
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // ************************************************************
    // Bus slave
    // ************************************************************
    cce_pkg::cce_bus_e  bus_q;
    cce_pkg::cce_bus_e  bus_d;
    logic               wait_q;
    logic               wait_d;
    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    logic [7:0]         mem_rdata;
    logic               is_file;
    logic               sw_wr;
    logic               sw_ctrl_wr;
    logic               sw_st_wr;
    logic               sw_file_wr;

    logic               exec_q;
    logic [10:0]        pc_q;
    logic [10:0]        stack_q;
    logic [7:0]         acc_q;
    logic [7:0]         status_q;
    logic [7:0]         ctrl_q;
    logic [7:0]         wdt_q;
    logic [7:0]         pre_q;

    assign is_file    = AVS_ADDRESS[cce_pkg::ADDR_FILE_BIT];
    assign sw_wr      = (bus_q == cce_pkg::BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];
    assign sw_ctrl_wr = sw_wr && (AVS_ADDRESS == cce_pkg::ADDR_CTRL);
    assign sw_st_wr   = sw_wr && (AVS_ADDRESS == cce_pkg::ADDR_STATUS);
    assign sw_file_wr = sw_wr && is_file;

    always_comb begin
        bus_d   = bus_q;
        wait_d  = wait_q;
        rdata_d = rdata_q;
        unique case (bus_q)
            cce_pkg::BUS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    bus_d = cce_pkg::BUS_WAIT;
                end
            end
            cce_pkg::BUS_WAIT: begin
                if (!(AVS_WRITE && is_file && cyc_next)) begin
                    bus_d   = cce_pkg::BUS_ACK;
                    wait_d  = 1'b0;
                    rdata_d = 32'h0000_0000;
                    if (AVS_READ) begin
                        if (is_file) begin
                            rdata_d[7:0] = mem_rdata;
                        end else begin
                            unique case (AVS_ADDRESS)
                                cce_pkg::ADDR_CTRL:   rdata_d[7:0]  = ctrl_q;
                                cce_pkg::ADDR_STATUS: rdata_d[7:0]  = status_q;
                                cce_pkg::ADDR_PC:     rdata_d[10:0] = pc_q;
                                cce_pkg::ADDR_STACK:  rdata_d[10:0] = stack_q;
                                cce_pkg::ADDR_ACC:    rdata_d[7:0]  = acc_q;
                                cce_pkg::ADDR_WDT:    rdata_d[7:0]  = wdt_q;
                                cce_pkg::ADDR_PRE:    rdata_d[7:0]  = pre_q;
                                default:              rdata_d       = 32'h0000_0000;
                            endcase
                        end
                    end
                end
            end
            cce_pkg::BUS_ACK: begin
                bus_d  = cce_pkg::BUS_IDLE;
                wait_d = 1'b1;
            end
            default: begin
                bus_d  = cce_pkg::BUS_IDLE;
                wait_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bus_q   <= cce_pkg::BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            bus_q   <= bus_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ************************************************************
    // Execution
    // ************************************************************
    cce_pkg::cce_dec_s  dec;
    cce_pkg::cce_exec_e state_q;
    cce_pkg::cce_exec_e state_d;
    logic               tick;
    logic               go;
    logic               psa;
    logic               wdt_step;
    logic               mem_we;
    logic [4:0]         mem_waddr;
    logic [7:0]         mem_wdata;
    logic [10:0]        pc_d;
    logic [10:0]        stack_d;
    logic [7:0]         acc_d;
    logic [7:0]         status_d;
    logic [7:0]         ctrl_d;
    logic [7:0]         wdt_d;
    logic [7:0]         pre_d;

    assign dec      = cce_pkg::cce_decode(INSTR_WORD);
    assign tick     = cyc_en && ctrl_q[cce_pkg::CTRL_RUN_BIT];
    assign go       = tick && (state_q == cce_pkg::ST_EXEC);
    assign psa      = ctrl_q[cce_pkg::CTRL_PSA_BIT];
    assign exec_q   = state_q == cce_pkg::ST_EXEC;
    assign wdt_step = !psa || (pre_q == cce_pkg::BYTE_FULL);

    // File clear owns the write port; bus file writes never land on an instruction tick
    assign mem_we    = (go && dec.file_reg_zero_op) || sw_file_wr;
    assign mem_waddr = (go && dec.file_reg_zero_op) ? dec.faddr : AVS_ADDRESS[4:0];
    assign mem_wdata = (go && dec.file_reg_zero_op) ? cce_pkg::BYTE_ZERO : AVS_WRITEDATA[7:0];

    always_comb begin
        state_d  = state_q;
        pc_d     = pc_q;
        stack_d  = stack_q;
        acc_d    = acc_q;
        status_d = status_q;
        ctrl_d   = ctrl_q;
        wdt_d    = wdt_q;
        pre_d    = pre_q;
        if (sw_ctrl_wr) begin
            ctrl_d = AVS_WRITEDATA[7:0];
        end
        if (sw_st_wr) begin
            status_d = AVS_WRITEDATA[7:0];
        end
        // Watchdog ticks once per instruction cycle, through the prescaler if assigned
        if (cyc_en) begin
            if (psa) begin
                pre_d = pre_q + 8'h01;
            end
            if (wdt_step) begin
                wdt_d = wdt_q + 8'h01;
                if (wdt_q == cce_pkg::BYTE_FULL) begin
                    status_d[cce_pkg::ST_TO_BIT] = 1'b0;
                end
            end
        end
        if (tick) begin
            unique case (state_q)
                cce_pkg::ST_EXEC: begin
                    pc_d = pc_q + 11'h001;
                    if (dec.call_op) begin
                        stack_d = pc_q + 11'h001;
                        pc_d[7:0] = dec.imm;
                        pc_d[10:9] = status_q[cce_pkg::ST_PAGE_HI:cce_pkg::ST_PAGE_LO];
                        pc_d[8] = 1'b0;
                        state_d = cce_pkg::ST_CALL2;
                    end
                    if (dec.file_reg_zero_op) begin
                        status_d[cce_pkg::ST_Z_BIT] = 1'b1;
                    end
                    if (dec.accumulator_zero_op) begin
                        acc_d = cce_pkg::BYTE_ZERO;
                        status_d[cce_pkg::ST_Z_BIT] = 1'b1;
                    end
                    if (dec.watchdog_kick_op) begin
                        wdt_d = cce_pkg::BYTE_ZERO;
                        if (psa) begin
                            pre_d = cce_pkg::BYTE_ZERO;
                        end
                        status_d[cce_pkg::ST_TO_BIT] = 1'b1;
                        status_d[cce_pkg::ST_PD_BIT] = 1'b1;
                    end
                end
                cce_pkg::ST_CALL2: begin
                    state_d = cce_pkg::ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= cce_pkg::ST_EXEC;
            pc_q     <= cce_pkg::PC_RST;
            stack_q  <= cce_pkg::PC_RST;
            acc_q    <= cce_pkg::BYTE_ZERO;
            status_q <= cce_pkg::STATUS_RST;
            ctrl_q   <= cce_pkg::CTRL_RST;
            wdt_q    <= cce_pkg::BYTE_ZERO;
            pre_q    <= cce_pkg::BYTE_ZERO;
        end else begin
            state_q  <= state_d;
            pc_q     <= pc_d;
            stack_q  <= stack_d;
            acc_q    <= acc_d;
            status_q <= status_d;
            ctrl_q   <= ctrl_d;
            wdt_q    <= wdt_d;
            pre_q    <= pre_d;
        end
    end

    cce_file_mem u_mem (
        .clk     (CORE_CLK),
        .rst_n   (rst_n),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (AVS_ADDRESS[4:0]),
        .rdata_q (mem_rdata)
    );

    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign FETCH_ADDR      = pc_q;
    assign STATUS_FLAGS    = status_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!rst_n);

    property p_call_push;
        go && dec.call_op |=> stack_q == $past(pc_q) + 11'h001;
    endproperty
    a_call_push: assert property (p_call_push) else $error("Call return address wrong");
    property p_call_low;
        go && dec.call_op |=> pc_q[7:0] == $past(INSTR_WORD[7:0]);
    endproperty
    a_call_low: assert property (p_call_low) else $error("Call target low byte wrong");
    property p_call_page;
        go && dec.call_op |=> pc_q[10:9] == $past(status_q[6:5]) && !pc_q[8];
    endproperty
    a_call_page: assert property (p_call_page) else $error("Call target page wrong");
    property p_call_two;
        go && dec.call_op && !sw_st_wr && !(wdt_step && wdt_q == cce_pkg::BYTE_FULL)
            |=> !exec_q && status_q[6:2] == $past(status_q[6:2]) ##[1:4] (cyc_en && !exec_q) ##1 exec_q;
    endproperty
    a_call_two: assert property (p_call_two) else $error("Call length or flags wrong");
    property p_fzero;
        go && dec.file_reg_zero_op |-> mem_we && mem_wdata == 8'h00 && mem_waddr == INSTR_WORD[4:0]
            ##1 status_q[2];
    endproperty
    a_fzero: assert property (p_fzero) else $error("File clear wrong");
    property p_azero;
        go && dec.accumulator_zero_op |=> acc_q == 8'h00 && status_q[2];
    endproperty
    a_azero: assert property (p_azero) else $error("Accumulator clear wrong");
    property p_kick_wdt;
        go && dec.watchdog_kick_op |=> wdt_q == 8'h00 ##3 wdt_q <= 8'h01;
    endproperty
    a_kick_wdt: assert property (p_kick_wdt) else $error("Watchdog not reset");
    property p_kick_pre;
        go && dec.watchdog_kick_op |=> (psa ? pre_q == 8'h00 : pre_q == $past(pre_q));
    endproperty
    a_kick_pre: assert property (p_kick_pre) else $error("Prescaler clear wrong");
    property p_kick_flags;
        go && dec.watchdog_kick_op |=> status_q[4] && status_q[3];
    endproperty
    a_kick_flags: assert property (p_kick_flags) else $error("Kick flags not set");
    property p_call_nop;
        tick && !exec_q |=> exec_q && pc_q == $past(pc_q) && acc_q == $past(acc_q);
    endproperty
    a_call_nop: assert property (p_call_nop) else $error("Second call cycle not idle");

endmodule : cce_exec

// ### logic/cce_pkg.sv
// Shared constants, types and decode function for the call and clear executor
package cce_pkg;

    // ************************************************************
    // Instruction cycle divider
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam logic [1:0]  CYC_DIV_LAST   = 2'h3;
    localparam logic [1:0]  CYC_DIV_NEXT   = 2'h2;

    // ************************************************************
    // Register word addresses
    // ************************************************************
    localparam logic [5:0]  ADDR_CTRL      = 6'h00;
    localparam logic [5:0]  ADDR_STATUS    = 6'h01;
    localparam logic [5:0]  ADDR_PC        = 6'h02;
    localparam logic [5:0]  ADDR_STACK     = 6'h03;
    localparam logic [5:0]  ADDR_ACC       = 6'h04;
    localparam logic [5:0]  ADDR_WDT       = 6'h05;
    localparam logic [5:0]  ADDR_PRE       = 6'h06;
    localparam int unsigned ADDR_FILE_BIT  = 5;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_PSA_BIT   = 1;
    localparam int unsigned ST_Z_BIT       = 2;
    localparam int unsigned ST_PD_BIT      = 3;
    localparam int unsigned ST_TO_BIT      = 4;
    localparam int unsigned ST_PAGE_LO     = 5;
    localparam int unsigned ST_PAGE_HI     = 6;
    localparam logic [7:0]  CTRL_RST       = 8'h01;
    localparam logic [7:0]  STATUS_RST     = 8'h18;
    localparam logic [10:0] PC_RST         = 11'h000;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [7:0]  BYTE_FULL      = 8'hFF;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [11:0] OP_CALL_MASK   = 12'hF00;
    localparam logic [11:0] OP_CALL_VAL    = 12'h900;
    localparam logic [11:0] OP_FZERO_MASK  = 12'hFE0;
    localparam logic [11:0] OP_FZERO_VAL   = 12'h060;
    localparam logic [11:0] OP_AZERO       = 12'h040;
    localparam logic [11:0] OP_KICK        = 12'h004;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [0:0] {
        ST_EXEC  = 1'b0,
        ST_CALL2 = 1'b1
    } cce_exec_e;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_ACK  = 2'b10
    } cce_bus_e;

    typedef struct packed {
        logic       call_op;
        logic       file_reg_zero_op;
        logic       accumulator_zero_op;
        logic       watchdog_kick_op;
        logic [4:0] faddr;
        logic [7:0] imm;
    } cce_dec_s;

    function automatic cce_dec_s cce_decode(input logic [11:0] w);
        cce_dec_s d;
        d.call_op             = (w & OP_CALL_MASK) == OP_CALL_VAL;
        d.file_reg_zero_op    = (w & OP_FZERO_MASK) == OP_FZERO_VAL;
        d.accumulator_zero_op = w == OP_AZERO;
        d.watchdog_kick_op    = w == OP_KICK;
        d.faddr               = w[4:0];
        d.imm                 = w[7:0];
        return d;
    endfunction : cce_decode

endpackage : cce_pkg

// ### logic/cce_file_mem.sv
// File register array with registered read data
`timescale 1ns/1ps
module cce_file_mem (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [4:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [4:0] raddr,
    output logic      [7:0] rdata_q
);

    logic [7:0] mem [0:31];

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule : cce_file_mem

// ### testbench/cce_prog_mem.sv
// Program memory model feeding instruction words to the executor
`timescale 1ns/1ps
module cce_prog_mem (
    input  wire logic        clk,
    input  wire logic [10:0] fetch_addr,
    input  wire logic        ld_en,
    input  wire logic [10:0] ld_addr,
    input  wire logic [11:0] ld_word,
    output logic      [11:0] instr_word
);
    // ****************************************
    // Storage, empty words hold a no-op code
    // ****************************************
    logic [11:0] mem [0:2047];

    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 12'h000;
        end
    end

    always @(posedge clk) begin
        if (ld_en) begin
            mem[ld_addr] <= ld_word;
        end
    end

    assign instr_word = mem[fetch_addr];
endmodule : cce_prog_mem

// ### testbench/tb.sv
// Self-checking bench for the call and clear executor
`timescale 1ns/1ps
module tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clk            = 1'b0;
    logic        rstn           = 1'b0;
    logic [5:0]  avs_address    = 6'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        ld_en          = 1'b0;
    logic [10:0] ld_addr        = 11'h000;
    logic [11:0] ld_word        = 12'h000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [10:0] fetch_addr;
    logic [7:0]  status_flags;
    logic [11:0] instr_word;
    logic [10:0] pc_log [$];
    logic [7:0]  fl_log [$];
    time         t_log [$];
    logic [10:0] pc_last        = 11'h7FF;
    logic [31:0] q;
    int          error_cnt      = 0;
    int          checks_done    = 0;
    int          n;

    always #4 clk = ~clk;

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    end

    cce_exec dut (
        .CORE_CLK       (clk),
        .RSTN           (rstn),
        .INSTR_WORD     (instr_word),
        .AVS_ADDRESS    (avs_address),
        .AVS_READ       (avs_read),
        .AVS_WRITE      (avs_write),
        .AVS_WRITEDATA  (avs_writedata),
        .AVS_BYTEENABLE (avs_byteenable),
        .AVS_READDATA   (avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest),
        .FETCH_ADDR     (fetch_addr),
        .STATUS_FLAGS   (status_flags)
    );

    cce_prog_mem pmem (
        .clk       (clk),
        .fetch_addr(fetch_addr),
        .ld_en     (ld_en),
        .ld_addr   (ld_addr),
        .ld_word   (ld_word),
        .instr_word(instr_word)
    );

    // Log of counter changes with flags and time
    always @(negedge clk) begin
        if (fetch_addr !== pc_last) begin
            pc_log.push_back(fetch_addr);
            fl_log.push_back(status_flags);
            t_log.push_back($time);
            pc_last = fetch_addr;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(q, exp, msg);
    endtask : rd

    task automatic ld(input logic [10:0] a, input logic [11:0] w);
        @(posedge clk);
        ld_en <= 1'b1;
        ld_addr <= a;
        ld_word <= w;
    endtask : ld

    task automatic wait_pc(input logic [10:0] a);
        pc_log.delete();
        fl_log.delete();
        t_log.delete();
        n = 0;
        while (fetch_addr !== a && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk({21'h0, fetch_addr}, {21'h0, a}, "counter target");
        repeat (12) @(negedge clk);
    endtask : wait_pc

    task automatic step(input int i, input logic [10:0] pc, input logic [7:0] fl, input int cyc);
        chk({21'h0, pc_log[i]}, {21'h0, pc}, "counter step");
        chk({24'h0, fl_log[i]}, {24'h0, fl}, "flags step");
        chk(32'((t_log[i + 1] - t_log[i]) / 8), 32'(cyc), "step length");
    endtask : step

    task automatic near(input time t0, input string msg);
        n = int'(($time - t0) / 32);
        chk({31'h0, (int'(q[7:0]) + 1 >= n) && (int'(q[7:0]) <= n + 1)}, 32'h1, msg);
    endtask : near

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        ld(11'h000, 12'h900);
        ld(11'h600, 12'h040);
        ld(11'h601, 12'h004);
        ld(11'h602, 12'h902);
        ld(11'h603, 12'h067);
        ld(11'h604, 12'h004);
        ld(11'h605, 12'h905);
        @(posedge clk);
        ld_en <= 1'b0;
        wait (rstn);
        repeat (12) @(posedge clk);
        rd(cce_pkg::ADDR_CTRL, 32'h01, "control reset");
        rd(cce_pkg::ADDR_STATUS, 32'h18, "status reset");
        rd(cce_pkg::ADDR_PC, 32'h000, "parked counter");
        rd(cce_pkg::ADDR_STACK, 32'h001, "return address");
        bus(1'b1, 6'h10, 8'hA5, 4'h1);
        rd(6'h10, 32'h0, "unmapped read");
        bus(1'b1, cce_pkg::ADDR_PC, 8'h55, 4'h1);
        rd(cce_pkg::ADDR_PC, 32'h000, "read-only counter");
        bus(1'b1, 6'h27, 8'h5A, 4'h1);
        bus(1'b1, 6'h27, 8'h11, 4'h0);
        rd(6'h27, 32'h5A, "file write");
        bus(1'b1, 6'h26, 8'h33, 4'h1);
        $display("test registers done");
        bus(1'b1, cce_pkg::ADDR_STATUS, 8'h60, 4'h1);
        wait_pc(11'h602);
        chk(32'(pc_log.size()), 32'd3, "step count");
        step(0, 11'h600, 8'h60, 8);
        step(1, 11'h601, 8'h64, 4);
        chk({24'h0, fl_log[2]}, 32'h7C, "kick flags");
        rd(cce_pkg::ADDR_ACC, 32'h00, "accumulator");
        rd(cce_pkg::ADDR_STACK, 32'h603, "paged return");
        bus(1'b0, cce_pkg::ADDR_WDT, 8'h00, 4'hF);
        near(t_log[2], "watchdog after kick");
        $display("test paged call done");
        bus(1'b1, cce_pkg::ADDR_STATUS, 8'h60, 4'h1);
        bus(1'b1, cce_pkg::ADDR_CTRL, 8'h03, 4'h1);
        ld(11'h602, 12'h000);
        @(posedge clk);
        ld_en <= 1'b0;
        wait_pc(11'h605);
        step(0, 11'h603, 8'h60, 4);
        step(1, 11'h604, 8'h64, 4);
        chk({24'h0, fl_log[2]}, 32'h7C, "kick flags");
        rd(6'h27, 32'h00, "cleared file");
        rd(6'h26, 32'h33, "other file");
        rd(cce_pkg::ADDR_WDT, 32'h00, "watchdog held");
        bus(1'b0, cce_pkg::ADDR_PRE, 8'h00, 4'hF);
        near(t_log[2], "prescaler after kick");
        $display("test file clear done");
        tally_and_finish();
    end
endmodule : tb
